//--- design/local_bus_arbiter_panel_status.sv
// Top: local bus arbiter, front panel indicators and switch actions
// Notes on behaviour
// RL1 - Grant by fixed priority: network, serial, disk, bridge, then processor lowest.
// RL2 - Local data bus is synchronous, thirty-two bit words between master and slave.
// RL3 - Bursts and snooping work under any master; grant holds through bursts. Code raises no snoop while the processor owns the bus.
// RL4 - Any granted master may reach any slave; no pair restrictions here.
// RL5 - Activity indicator lit while transfer-in-progress line is low.
// RL6 - Network indicator lit exactly while network controller owns the bus.
// RL7 - Disk indicator lit exactly while disk controller owns the bus.
// RL8 - System-bus indicator lit on bridge address strobe or bridge bus ownership.
// RL9 - Failure indicator lit while board-fail line is active.
// RL10 - Processor-status indicator lit while processor is halted.
// RL11 - System-controller indicator lit while board is system controller.
// RL12 - Reset switch resets onboard devices; drives system reset only as controller.
// RL13 - Software control can disable the reset switch entirely.
// RL14 - Enabled abort switch raises interrupt at programmed level; else nothing.
// RL15 - At most one grant; re-arbitrate only after owner's cycle or burst ends. Code also releases if the owner drops its request while idle.
`timescale 1ns/1ps
`default_nettype none
module local_bus_arbiter_panel_status
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Bus requests and cycle status
   input wire logic [arb_pkg::NUM_MASTERS-1:0] i_bus_req,
   input wire logic i_transfer_in_progress_n,
   input wire logic i_burst_active,
   // Data path from owners to slaves
   input wire logic [arb_pkg::DATA_W-1:0] i_master_wdata [arb_pkg::NUM_MASTERS],
   output logic [arb_pkg::DATA_W-1:0] o_slave_wdata,
   // Grants and snoop strobe
   output logic [arb_pkg::NUM_MASTERS-1:0] o_bus_grant,
   output logic o_snoop_enable,
   // Board state
   input wire logic i_board_fail,
   input wire logic i_cpu_halted,
   input wire logic i_system_controller,
   input wire logic i_bridge_addr_strobe,
   // Switches and software controls
   input wire logic i_reset_switch,
   input wire logic i_reset_switch_enable,
   input wire logic i_abort_switch,
   input wire logic i_abort_enable,
   input wire logic [arb_pkg::LEVEL_W-1:0] i_abort_level,
   // Panel indicators
   output logic o_activity_indicator,
   output logic o_network_master_indicator,
   output logic o_disk_master_indicator,
   output logic o_system_bus_indicator,
   output logic o_fail_indicator,
   output logic o_cpu_status_indicator,
   output logic o_system_controller_indicator,
   // Reset and interrupt outputs
   output logic o_board_reset,
   output logic o_sys_reset_drive,
   output logic o_abort_irq,
   output logic [arb_pkg::LEVEL_W-1:0] o_abort_irq_level
);

   // ==========================================================
   // Arbitration
   grant_if g ();
   arb_pkg::arb_state_e state_reg, state_next;
   arb_pkg::master_vec_t grant_reg, grant_next;
   logic cycle_seen_reg, cycle_seen_next;
   logic bus_busy;

   assign g.req = i_bus_req;
   assign bus_busy = !i_transfer_in_progress_n || i_burst_active;

   prio_pick prio_pick_inst
   (
      .g(g)
   );

   always_comb
   begin
      state_next = state_reg;
      grant_next = grant_reg;
      cycle_seen_next = cycle_seen_reg;
      unique case (state_reg)
         arb_pkg::ARB_IDLE:
         begin
            if (g.pick != '0 && !bus_busy)
            begin
               grant_next = g.pick; // RL1
               cycle_seen_next = 1'b0;
               state_next = arb_pkg::ARB_OWNED;
            end
         end
         arb_pkg::ARB_OWNED:
         begin
            if (bus_busy)
            begin
               cycle_seen_next = 1'b1;
            end
            // Release after the owner's cycle or burst, or if it drops request idle
            if ((cycle_seen_reg && !bus_busy) || ((grant_reg & i_bus_req) == '0 && !bus_busy))
            begin
               grant_next = '0; // RL15
               state_next = arb_pkg::ARB_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         state_reg <= arb_pkg::ARB_IDLE;
         grant_reg <= '0;
         cycle_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         grant_reg <= grant_next;
         cycle_seen_reg <= cycle_seen_next;
      end
   end

   assign o_bus_grant = grant_reg; // RL15

   // ==========================================================
   // Data routing from the owner, any slave
   logic [arb_pkg::DATA_W-1:0] wdata_reg, wdata_next;
   logic snoop_reg, snoop_next;

   always_comb
   begin
      wdata_next = '0;
      for (int i = 0; i < int'(arb_pkg::NUM_MASTERS); i++)
      begin
         if (grant_reg[i])
         begin
            wdata_next = i_master_wdata[i]; // RL2 RL4
         end
      end
      // Processor snoops while another master owns the bus and a cycle or burst is running
      snoop_next = (grant_reg != '0) && !grant_reg[arb_pkg::M_CPU] && bus_busy; // RL3
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         wdata_reg <= '0;
         snoop_reg <= 1'b0;
      end
      else
      begin
         wdata_reg <= wdata_next;
         snoop_reg <= snoop_next;
      end
   end

   assign o_slave_wdata = wdata_reg;
   assign o_snoop_enable = snoop_reg;

   // ==========================================================
   // Panel indicators
   logic [6:0] led_reg, led_next;

   always_comb
   begin
      led_next[0] = !i_transfer_in_progress_n; // RL5
      led_next[1] = grant_next[arb_pkg::M_NET]; // RL6
      led_next[2] = grant_next[arb_pkg::M_DISK]; // RL7
      led_next[3] = i_bridge_addr_strobe || grant_next[arb_pkg::M_BRIDGE]; // RL8
      led_next[4] = i_board_fail; // RL9
      led_next[5] = i_cpu_halted; // RL10
      led_next[6] = i_system_controller; // RL11
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         led_reg <= '0;
      end
      else
      begin
         led_reg <= led_next;
      end
   end

   assign o_activity_indicator = led_reg[0];
   assign o_network_master_indicator = led_reg[1];
   assign o_disk_master_indicator = led_reg[2];
   assign o_system_bus_indicator = led_reg[3];
   assign o_fail_indicator = led_reg[4];
   assign o_cpu_status_indicator = led_reg[5];
   assign o_system_controller_indicator = led_reg[6];

   // ==========================================================
   // Reset switch and abort switch
   logic rst_sw_prev_reg, rst_sw_prev_next;
   logic abort_prev_reg, abort_prev_next;
   logic [arb_pkg::RESET_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
   logic board_rst_reg, board_rst_next;
   logic sys_rst_reg, sys_rst_next;
   logic irq_reg, irq_next;
   logic [arb_pkg::LEVEL_W-1:0] lvl_reg, lvl_next;

   always_comb
   begin
      rst_sw_prev_next = i_reset_switch;
      abort_prev_next = i_abort_switch;
      rst_cnt_next = rst_cnt_reg;
      sys_rst_next = sys_rst_reg;
      if (i_reset_switch && !rst_sw_prev_reg && i_reset_switch_enable) // RL13
      begin
         rst_cnt_next = arb_pkg::RESET_CNT_W'(arb_pkg::RESET_PULSE_CYCLES);
         sys_rst_next = i_system_controller; // RL12
      end
      else if (rst_cnt_reg != '0)
      begin
         rst_cnt_next = rst_cnt_reg - 1'b1;
      end
      else
      begin
         sys_rst_next = 1'b0;
      end
      board_rst_next = (rst_cnt_next != '0); // RL12
      sys_rst_next = sys_rst_next && board_rst_next; // RL12
      irq_next = irq_reg;
      lvl_next = lvl_reg;
      if (!i_abort_enable)
      begin
         irq_next = 1'b0; // RL14
      end
      else if (i_abort_switch && !abort_prev_reg)
      begin
         irq_next = 1'b1; // RL14
         lvl_next = i_abort_level;
      end
      else if (!i_abort_switch)
      begin
         irq_next = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         rst_sw_prev_reg <= 1'b0;
         abort_prev_reg <= 1'b0;
         rst_cnt_reg <= '0;
         board_rst_reg <= 1'b0;
         sys_rst_reg <= 1'b0;
         irq_reg <= 1'b0;
         lvl_reg <= '0;
      end
      else
      begin
         rst_sw_prev_reg <= rst_sw_prev_next;
         abort_prev_reg <= abort_prev_next;
         rst_cnt_reg <= rst_cnt_next;
         board_rst_reg <= board_rst_next;
         sys_rst_reg <= sys_rst_next;
         irq_reg <= irq_next;
         lvl_reg <= lvl_next;
      end
   end

   assign o_board_reset = board_rst_reg;
   assign o_sys_reset_drive = sys_rst_reg;
   assign o_abort_irq = irq_reg;
   assign o_abort_irq_level = lvl_reg;

endmodule
`default_nettype wire

//--- design/prio_pick.sv
// Fixed-priority one-hot picker for the local bus masters
`timescale 1ns/1ps
`default_nettype none
module prio_pick
(
   grant_if.chooser g
);

   // Lowest index wins; result is one-hot or zero
   always_comb
   begin
      g.pick = '0;
      for (int i = int'(arb_pkg::NUM_MASTERS) - 1; i >= 0; i--)
      begin
         if (g.req[i])
         begin
            g.pick = '0;
            g.pick[i] = 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

//--- shared/arb_pkg.sv
// Package: constants and types for the local bus arbiter and panel logic
package arb_pkg;

   // Master indices, highest priority first
   localparam int unsigned NUM_MASTERS = 5;
   localparam int unsigned M_NET = 0;
   localparam int unsigned M_SERIAL = 1;
   localparam int unsigned M_DISK = 2;
   localparam int unsigned M_BRIDGE = 3;
   localparam int unsigned M_CPU = 4;

   // Data word width on the local bus
   localparam int unsigned DATA_W = 32;

   // Width of the abort interrupt level field
   localparam int unsigned LEVEL_W = 3;

   // Reset pulse length in clock cycles
   localparam int unsigned RESET_PULSE_CYCLES = 16;
   localparam int unsigned RESET_CNT_W = 5;

   typedef logic [NUM_MASTERS-1:0] master_vec_t;

   typedef enum logic [1:0]
   {
      ARB_IDLE,
      ARB_OWNED
   } arb_state_e;

endpackage

//--- shared/grant_if.sv
// Interface: request and grant vectors between the top and the priority picker
`timescale 1ns/1ps
`default_nettype none
interface grant_if;
   arb_pkg::master_vec_t req;
   arb_pkg::master_vec_t pick;
   modport chooser (input req, output pick);
   modport user (output req, input pick);
endinterface
`default_nettype wire

//--- sim/bus_masters.sv
// Model: local bus masters that request, run cycles or bursts, then release
`timescale 1ns/1ps
`default_nettype none
module bus_masters
(
   // Clock, reset and bench control
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [4:0] start,
   input wire logic burst,
   // Arbiter side
   input wire logic [4:0] o_bus_grant,
   output logic [4:0] i_bus_req,
   output logic i_transfer_in_progress_n,
   output logic i_burst_active,
   output logic [31:0] i_master_wdata [5]
);
   // ====
   // Owner runs six cycles, toggling busy inside a burst
   int left;
   always_comb
      for (int k = 0; k < 5; k++)
         i_master_wdata[k] = {16'hA5A5, 16'(k)};
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         i_bus_req <= 5'h00;
         i_transfer_in_progress_n <= 1'b1;
         i_burst_active <= 1'b0;
         left <= 0;
      end
      else
      begin
         i_bus_req <= (i_bus_req | start) & ~((left == 1) ? o_bus_grant : 5'h00);
         if (left > 0)
         begin
            left <= left - 1;
            i_transfer_in_progress_n <= (left == 1) || (burst && left[0]);
            i_burst_active <= burst && left > 1;
         end
         else if ((o_bus_grant & i_bus_req) != 5'h00)
         begin
            left <= 6;
            i_transfer_in_progress_n <= 1'b0;
            i_burst_active <= burst;
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/lbus_monitor.sv
// Checker: port properties of the arbiter and panel block
`timescale 1ns/1ps
`default_nettype none
module lbus_monitor
(
   // Clock, reset and inputs
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [4:0] i_bus_req,
   input wire logic i_transfer_in_progress_n,
   input wire logic i_burst_active,
   input wire logic i_bridge_addr_strobe,
   input wire logic i_reset_switch,
   input wire logic i_reset_switch_enable,
   input wire logic i_abort_switch,
   input wire logic i_abort_enable,
   input wire logic [2:0] i_abort_level,
   // Outputs
   input wire logic [4:0] o_bus_grant,
   input wire logic o_activity_indicator,
   input wire logic o_network_master_indicator,
   input wire logic o_disk_master_indicator,
   input wire logic o_system_bus_indicator,
   input wire logic o_board_reset,
   input wire logic o_sys_reset_drive,
   input wire logic o_abort_irq,
   input wire logic [2:0] o_abort_irq_level
);
   // ====
   // Properties
   logic [4:0] lowest;
   assign lowest = i_bus_req & (~i_bus_req + 5'h01);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   property p_one; $onehot0(o_bus_grant); endproperty
   a_one: assert property (p_one) else $error("two grants");
   property p_prio; o_bus_grant == 5'h00 && i_transfer_in_progress_n && !i_burst_active && |i_bus_req
      |=> o_bus_grant == $past(lowest); endproperty
   a_prio: assert property (p_prio) else $error("wrong winner");
   property p_hold; o_bus_grant != 5'h00 && (!i_transfer_in_progress_n || i_burst_active)
      |=> o_bus_grant == $past(o_bus_grant); endproperty
   a_hold: assert property (p_hold) else $error("grant moved during cycle");
   property p_sys_rst; o_sys_reset_drive |-> o_board_reset; endproperty
   a_sys_rst: assert property (p_sys_rst) else $error("system reset without board reset");
   property p_net; o_network_master_indicator == o_bus_grant[0]; endproperty
   a_net: assert property (p_net) else $error("net lamp");
   property p_disk; o_disk_master_indicator == o_bus_grant[2]; endproperty
   a_disk: assert property (p_disk) else $error("disk lamp");
   property p_act; 1 |=> o_activity_indicator == !$past(i_transfer_in_progress_n); endproperty
   a_act: assert property (p_act) else $error("activity lamp");
   property p_sys; 1 |=> o_system_bus_indicator == ($past(i_bridge_addr_strobe) || o_bus_grant[3]); endproperty
   a_sys: assert property (p_sys) else $error("system bus lamp");
   property p_rst_on; $rose(i_reset_switch) && i_reset_switch_enable |=> o_board_reset [*8]; endproperty
   a_rst_on: assert property (p_rst_on) else $error("no reset pulse");
   property p_rst_off; $rose(i_reset_switch) && !i_reset_switch_enable && !o_board_reset |=> !o_board_reset;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("disabled reset acted");
   property p_abort; $rose(i_abort_switch) && i_abort_enable
      |=> o_abort_irq && o_abort_irq_level == $past(i_abort_level); endproperty
   a_abort: assert property (p_abort) else $error("abort irq");
   c_burst: cover property (o_bus_grant == 5'h04 && i_burst_active);
   c_rst: cover property (o_board_reset);
   c_abort: cover property (o_abort_irq);
endmodule
bind local_bus_arbiter_panel_status lbus_monitor lbus_monitor_inst (.*);
`default_nettype wire

//--- sim/local_bus_arbiter_panel_status_test.sv
// Testbench: arbitration, bursts, panel lamps and switch actions
`timescale 1ns/1ps
`default_nettype none
module local_bus_arbiter_panel_status_test;
   logic i_ref_clk = 0, i_reset = 1, burst = 0;
   logic [4:0] start = 5'h00;
   logic i_board_fail = 0, i_cpu_halted = 0, i_system_controller = 0, i_bridge_addr_strobe = 0;
   logic i_reset_switch = 0, i_reset_switch_enable = 0, i_abort_switch = 0, i_abort_enable = 0;
   logic [2:0] i_abort_level = 3'h0, o_abort_irq_level;
   logic [4:0] i_bus_req, o_bus_grant;
   logic [31:0] i_master_wdata [5];
   logic [31:0] o_slave_wdata;
   logic i_transfer_in_progress_n, i_burst_active, o_snoop_enable, o_activity_indicator;
   logic o_network_master_indicator, o_disk_master_indicator, o_system_bus_indicator, o_fail_indicator;
   logic o_cpu_status_indicator, o_system_controller_indicator, o_board_reset, o_sys_reset_drive, o_abort_irq;
   int miscompares = 0, num_checks = 0, cycles = 0;
   local_bus_arbiter_panel_status local_bus_arbiter_panel_status_inst (.*);
   bus_masters bus_masters_inst (.*);
   always #20 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         miscompares++;
         close_out();
      end
   end
   // ====
   // Helpers
   task automatic close_out();
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wait_grant();
      for (int n = 0; n < 20 && o_bus_grant === 5'h00; n++)
         @(negedge i_ref_clk);
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 20 && o_bus_grant !== 5'h00; n++)
         @(negedge i_ref_clk);
   endtask
   // ====
   // Scenarios
   task automatic t_prio();
      @(posedge i_ref_clk);
      start <= 5'h1F;
      @(posedge i_ref_clk);
      start <= 5'h00;
      for (int k = 0; k < 5; k++)
      begin
         wait_grant();
         chk("grant", 32'h1 << k, o_bus_grant);
         chk("network lamp", k == 0, o_network_master_indicator);
         chk("disk lamp", k == 2, o_disk_master_indicator);
         repeat (3) @(negedge i_ref_clk);
         chk("activity", 1, o_activity_indicator);
         chk("data", {16'hA5A5, 16'(k)}, o_slave_wdata);
         wait_idle();
         chk("idle activity", 0, o_activity_indicator);
      end
   endtask
   task automatic t_burst();
      @(posedge i_ref_clk);
      burst <= 1;
      start <= 5'h04;
      @(posedge i_ref_clk);
      start <= 5'h01;
      wait_grant();
      @(posedge i_ref_clk);
      start <= 5'h00;
      repeat (4) @(negedge i_ref_clk);
      chk("burst grant", 32'h04, o_bus_grant);
      chk("snoop", 1, o_snoop_enable);
      wait_idle();
      wait_grant();
      chk("next grant", 32'h01, o_bus_grant);
      wait_idle();
      @(posedge i_ref_clk);
      burst <= 0;
   endtask
   task automatic t_panel();
      for (int v = 1; v >= 0; v--)
      begin
         @(posedge i_ref_clk);
         {i_board_fail, i_cpu_halted, i_system_controller, i_bridge_addr_strobe} <= {4{v[0]}};
         repeat (3) @(negedge i_ref_clk);
         chk("fail lamp", v, o_fail_indicator);
         chk("status lamp", v, o_cpu_status_indicator);
         chk("controller lamp", v, o_system_controller_indicator);
         chk("system bus lamp", v, o_system_bus_indicator);
      end
   endtask
   task automatic t_rst(logic en, logic ctrl);
      int n = 0;
      int s = 0;
      @(posedge i_ref_clk);
      i_reset_switch_enable <= en;
      i_system_controller <= ctrl;
      @(posedge i_ref_clk);
      i_reset_switch <= 1;
      repeat (30)
      begin
         @(negedge i_ref_clk);
         n += (o_board_reset === 1'b1);
         s += (o_sys_reset_drive === 1'b1);
      end
      chk("reset length", en ? arb_pkg::RESET_PULSE_CYCLES : 0, n);
      chk("system reset", (en && ctrl) ? arb_pkg::RESET_PULSE_CYCLES : 0, s);
      @(posedge i_ref_clk);
      i_reset_switch <= 0;
   endtask
   task automatic t_abort(logic en, logic [2:0] lvl);
      @(posedge i_ref_clk);
      i_abort_enable <= en;
      i_abort_level <= lvl;
      @(posedge i_ref_clk);
      i_abort_switch <= 1;
      repeat (3) @(negedge i_ref_clk);
      chk("abort irq", en, o_abort_irq);
      if (en)
         chk("abort level", lvl, o_abort_irq_level);
      @(posedge i_ref_clk);
      i_abort_switch <= 0;
      repeat (2) @(negedge i_ref_clk);
      chk("abort clear", 0, o_abort_irq);
   endtask
   initial
   begin
      repeat (10) @(posedge i_ref_clk);
      i_reset <= 0;
      t_prio();
      t_burst();
      t_panel();
      t_rst(0, 1);
      t_rst(1, 1);
      t_rst(1, 0);
      t_abort(1, 3'h5);
      t_abort(0, 3'h2);
      close_out();
   end
endmodule
`default_nettype wire
